// *** logic/mem_decode_map.svh ***
`ifndef MEM_DECODE_MAP_SVH
`define MEM_DECODE_MAP_SVH
// Size register reset value and variant codes
`define MSD_SIZE_RESET   8'hCF
`define MSD_SIZE_8K      8'h42
`define MSD_SIZE_16K     8'h44
`define MSD_SIZE_24K     8'hC6
`define MSD_SIZE_32K     8'hC8
// Size register fields
`define MSD_SIZE_ROM_LSB 0
`define MSD_SIZE_ROM_MSB 3
`define MSD_SIZE_RAM_BIT 7
// Internal ROM end addresses
`define MSD_ROM_END_8K   16'h1FFF
`define MSD_ROM_END_16K  16'h3FFF
`define MSD_ROM_END_24K  16'h5FFF
`define MSD_ROM_END_32K  16'h7FFF
// Vector table and slots, slot index is address / 2
`define MSD_VEC_BASE     16'h0000
`define MSD_VEC_END      16'h003F
`define MSD_SLOT_RESET   5'h00
`define MSD_SLOT_WDT     5'h02
`define MSD_SLOT_EXT_LO  5'h03
`define MSD_SLOT_PER_HI  5'h13
`define MSD_SLOT_KEY     5'h14
`define MSD_SLOT_BREAK   5'h1F
// Call tables
`define MSD_TCALL_BASE   16'h0040
`define MSD_TCALL_END    16'h007F
`define MSD_FCALL_BASE   16'h0800
`define MSD_FCALL_END    16'h0FFF
// Internal RAM, register banks, peripheral window
`define MSD_RAM_BASE_512 16'hFD00
`define MSD_RAM_BASE_1K  16'hFB00
`define MSD_RAM_END      16'hFEFF
`define MSD_BANK_BASE    16'hFEE0
`define MSD_SFR_BASE     16'hFF00
`define MSD_SFR_END      16'hFFFF
`endif

// *** logic/mem_decode_pkg.sv ***
package mem_decode_pkg;
   // Target of a decoded access
   typedef enum logic [2:0] {
      RG_NONE, RG_ROM, RG_RAM, RG_BANK, RG_SFR, RG_EXT
   } region_t;
   // Kind of CPU access
   typedef enum logic [2:0] {
      ACC_FETCH, ACC_READ, ACC_WRITE, ACC_PUSH, ACC_POP
   } access_t;
   // Vector word fetch sequence
   typedef enum logic [1:0] {
      VF_IDLE, VF_RD_LO, VF_RD_HI, VF_GET_HI
   } vf_state_t;
endpackage

// *** logic/vector_fetch.sv ***
`include "mem_decode_map.svh"

module vector_fetch (
   input  wire logic        clk,      // CPU clock
   input  wire logic        rst,      // Async reset, active high
   input  wire logic        start,    // Begin a word fetch
   input  wire logic [15:0] base,     // Even address of the entry
   input  wire logic [7:0]  rd_data,  // ROM byte, one cycle after rd_en
   output logic             rd_en,    // ROM byte read strobe
   output logic [15:0]      rd_addr,  // ROM byte address
   output logic             busy,     // Sequence in progress
   output logic             done,     // Vector valid pulse
   output logic [15:0]      vector    // Assembled entry
);
   mem_decode_pkg::vf_state_t state_reg;
   logic [7:0]                lo_reg;

   ////////////////////////////////////////////////////////////////////
   // Two byte reads, even address first, then the odd one
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_reg <= mem_decode_pkg::VF_IDLE;
         rd_en     <= 1'b0;
         rd_addr   <= 16'h0000;
         busy      <= 1'b0;
         done      <= 1'b0;
         lo_reg    <= 8'h00;
         vector    <= 16'h0000;
      end else begin
         done <= 1'b0;
         unique case (state_reg)
            mem_decode_pkg::VF_IDLE: begin
               if (start) begin
                  rd_en     <= 1'b1;
                  rd_addr   <= {base[15:1], 1'b0};
                  busy      <= 1'b1;
                  state_reg <= mem_decode_pkg::VF_RD_LO;
               end
            end
            mem_decode_pkg::VF_RD_LO: begin
               rd_addr   <= {rd_addr[15:1], 1'b1};
               state_reg <= mem_decode_pkg::VF_RD_HI;
            end
            mem_decode_pkg::VF_RD_HI: begin
               lo_reg    <= rd_data;              // Low byte
               rd_en     <= 1'b0;
               state_reg <= mem_decode_pkg::VF_GET_HI;
            end
            mem_decode_pkg::VF_GET_HI: begin
               vector    <= {rd_data, lo_reg};    // High byte
               done      <= 1'b1;
               busy      <= 1'b0;
               state_reg <= mem_decode_pkg::VF_IDLE;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Even read, odd read, then the word two cycles after the odd read
   sequence s_even_odd;
      rd_en && !rd_addr[0] ##1 rd_en && rd_addr[0];
   endsequence
   property p_pair;
      @(posedge clk) disable iff (rst)
      (start && !busy) |=> s_even_odd ##2 done;
   endproperty
   a_vec_byte_pair: assert property (p_pair)
      else $error("vector bytes not read even then odd");
endmodule

// *** logic/mem_space_decode.sv ***
`include "mem_decode_map.svh"

////////////////////////////////////////////////////////////////////////
module mem_space_decode (
   input  wire logic                          clk,         // CPU clock
   input  wire logic                          rst,         // Async reset
   input  wire logic                          req,         // Access strobe
   input  wire mem_decode_pkg::access_t       acc,         // Access kind
   input  wire logic [15:0]                   addr,        // Data address
   input  wire logic [15:0]                   pc,          // Program counter
   input  wire logic                          size_wr,     // Size reg write
   input  wire logic [7:0]                    size_wdata,  // Size reg data
   input  wire logic                          ext_en,      // Expansion on
   input  wire logic                          vec_req,     // Vector fetch
   input  wire logic [4:0]                    vec_slot,    // Address / 2
   input  wire logic                          tcall_req,   // Table call
   input  wire logic [4:0]                    tcall_idx,   // Table entry
   input  wire logic                          fcall_req,   // Fixed call
   input  wire logic [10:0]                   fcall_off,   // Call offset
   input  wire logic [7:0]                    rom_rd_data, // ROM byte
   output logic                               ack,         // Access done
   output mem_decode_pkg::region_t            region,      // Target
   output logic [15:0]                        loc_addr,    // Local offset
   output logic [1:0]                         bank_sel,    // Bank number
   output logic [2:0]                         bank_reg,    // Register in bank
   output logic                               fault,       // Unserviced
   output logic                               fetch_fault, // Bad fetch
   output logic [7:0]                         size_out,    // Size register
   output logic [15:0]                        rom_limit,   // ROM last byte
   output logic [15:0]                        ram_base,    // RAM first byte
   output logic                               vec_busy,    // Word fetch busy
   output logic                               vec_done,    // Word ready
   output logic [15:0]                        vec_out,     // Fetched word
   output logic                               rom_rd_en,   // ROM read
   output logic [15:0]                        rom_rd_addr, // ROM address
   output logic                               fcall_ok,    // Target ready
   output logic [15:0]                        fcall_target // Call target
);
   logic [7:0]                 size_reg;
   logic [15:0]                rom_end_reg;
   logic [15:0]                ram_base_reg;
   logic                       ack_reg;
   mem_decode_pkg::region_t    region_reg;
   logic [15:0]                loc_reg;
   logic [1:0]                 bank_sel_reg;
   logic [2:0]                 bank_reg_reg;
   logic                       fault_reg;
   logic                       ffault_reg;
   logic                       fcall_ok_reg;
   logic [15:0]                fcall_tgt_reg;

   logic [15:0]                eff_addr;
   mem_decode_pkg::region_t    rg;
   mem_decode_pkg::region_t    region_next;
   logic [15:0]                loc_next;
   logic                       fault_next;
   logic                       ffault_next;
   logic                       vf_start;
   logic [15:0]                vf_base;
   logic                       vec_bad;

   ////////////////////////////////////////////////////////////////////
   // Decoding helpers, shared by the size update and the decoder
   function automatic logic [15:0] rom_end_of(input logic [7:0] code);
      unique case (code[`MSD_SIZE_ROM_MSB:`MSD_SIZE_ROM_LSB])
         4'h2:    rom_end_of = `MSD_ROM_END_8K;
         4'h4:    rom_end_of = `MSD_ROM_END_16K;
         4'h6:    rom_end_of = `MSD_ROM_END_24K;
         default: rom_end_of = `MSD_ROM_END_32K;
      endcase
   endfunction

   function automatic logic [15:0] ram_base_of(input logic [7:0] code);
      ram_base_of = code[`MSD_SIZE_RAM_BIT] ? `MSD_RAM_BASE_1K
                                            : `MSD_RAM_BASE_512;
   endfunction

   // Top-down priority keeps the windows disjoint over all 64 KB
   function automatic mem_decode_pkg::region_t classify(
      input logic [15:0] a,
      input logic [15:0] rom_end,
      input logic [15:0] ram_lo,
      input logic        ext
   );
      if (a >= `MSD_SFR_BASE)
         classify = mem_decode_pkg::RG_SFR;
      else if (a >= `MSD_BANK_BASE)
         classify = mem_decode_pkg::RG_BANK;
      else if (a >= ram_lo)
         classify = mem_decode_pkg::RG_RAM;
      else if (a <= rom_end)
         classify = mem_decode_pkg::RG_ROM;
      else if (ext)
         classify = mem_decode_pkg::RG_EXT;
      else
         classify = mem_decode_pkg::RG_NONE;
   endfunction

   // Only documented slots have a source behind them
   function automatic logic slot_ok(input logic [4:0] s);
      slot_ok = (s == `MSD_SLOT_RESET) || (s == `MSD_SLOT_WDT) ||
                (s >= `MSD_SLOT_EXT_LO && s <= `MSD_SLOT_PER_HI) ||
                (s == `MSD_SLOT_KEY) || (s == `MSD_SLOT_BREAK);
   endfunction

   ////////////////////////////////////////////////////////////////////
   // Size register; sizes are cached so decode never lags a write
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         size_reg     <= `MSD_SIZE_RESET;
         rom_end_reg  <= `MSD_ROM_END_32K;
         ram_base_reg <= `MSD_RAM_BASE_1K;
      end else if (size_wr) begin
         size_reg     <= size_wdata;
         rom_end_reg  <= rom_end_of(size_wdata);
         ram_base_reg <= ram_base_of(size_wdata);
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Address decode for one access
   always_comb begin
      eff_addr = (acc == mem_decode_pkg::ACC_FETCH) ? pc : addr;
      rg = classify(eff_addr, rom_end_reg, ram_base_reg, ext_en);
      region_next = rg;
      loc_next    = eff_addr;
      fault_next  = 1'b0;
      ffault_next = 1'b0;
      unique case (rg)
         mem_decode_pkg::RG_ROM:  loc_next = eff_addr;
         mem_decode_pkg::RG_RAM:  loc_next = eff_addr - ram_base_reg;
         mem_decode_pkg::RG_BANK: begin
            loc_next = eff_addr - ram_base_reg;
         end
         mem_decode_pkg::RG_SFR:  loc_next = {8'h00, eff_addr[7:0]};
         mem_decode_pkg::RG_EXT:  loc_next = eff_addr;
         mem_decode_pkg::RG_NONE: fault_next = 1'b1;
      endcase
      // Banks hold data only, never code
      if (acc == mem_decode_pkg::ACC_FETCH &&
          rg == mem_decode_pkg::RG_BANK) begin
         region_next = mem_decode_pkg::RG_NONE;
         ffault_next = 1'b1;
         fault_next  = 1'b1;
      end
      // Stack may only live in internal RAM
      if ((acc == mem_decode_pkg::ACC_PUSH ||
           acc == mem_decode_pkg::ACC_POP) &&
          rg != mem_decode_pkg::RG_RAM &&
          rg != mem_decode_pkg::RG_BANK) begin
         region_next = mem_decode_pkg::RG_NONE;
         fault_next  = 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Registered access answer, one cycle after the strobe
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ack_reg      <= 1'b0;
         region_reg   <= mem_decode_pkg::RG_NONE;
         loc_reg      <= 16'h0000;
         bank_sel_reg <= 2'h0;
         bank_reg_reg <= 3'h0;
         ffault_reg   <= 1'b0;
      end else begin
         ack_reg    <= req;
         ffault_reg <= req && ffault_next;
         if (req) begin
            region_reg   <= region_next;
            loc_reg      <= loc_next;
            // Bank 0 sits at the top, bank 3 at the bottom
            bank_sel_reg <= 2'h3 - eff_addr[4:3];
            bank_reg_reg <= eff_addr[2:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Fault pulse covers both bad accesses and bad vector slots
   always_ff @(posedge clk or posedge rst) begin
      if (rst)
         fault_reg <= 1'b0;
      else
         fault_reg <= (req && fault_next) || vec_bad;
   end

   ////////////////////////////////////////////////////////////////////
   // Vector and table-call word fetch; vectors win over table calls.
   // Requests that arrive while busy are dropped, not queued.
   always_comb begin
      vec_bad  = vec_req && !vec_busy && !slot_ok(vec_slot);
      vf_start = 1'b0;
      vf_base  = `MSD_VEC_BASE;
      if (!vec_busy) begin
         if (vec_req) begin
            vf_start = slot_ok(vec_slot);
            vf_base  = `MSD_VEC_BASE + {10'h000, vec_slot, 1'b0};
         end else if (tcall_req) begin
            vf_start = 1'b1;
            vf_base  = `MSD_TCALL_BASE + {10'h000, tcall_idx, 1'b0};
         end
      end
   end

   vector_fetch u_vector_fetch (
      .clk     (clk),
      .rst     (rst),
      .start   (vf_start),
      .base    (vf_base),
      .rd_data (rom_rd_data),
      .rd_en   (rom_rd_en),
      .rd_addr (rom_rd_addr),
      .busy    (vec_busy),
      .done    (vec_done),
      .vector  (vec_out)
   );

   ////////////////////////////////////////////////////////////////////
   // Fixed call: offset is 11 bits, so the target cannot escape
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         fcall_ok_reg  <= 1'b0;
         fcall_tgt_reg <= 16'h0000;
      end else begin
         fcall_ok_reg <= fcall_req;
         if (fcall_req)
            fcall_tgt_reg <= `MSD_FCALL_BASE | {5'h00, fcall_off};
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Outputs straight from flops
   assign ack          = ack_reg;
   assign region       = region_reg;
   assign loc_addr     = loc_reg;
   assign bank_sel     = bank_sel_reg;
   assign bank_reg     = bank_reg_reg;
   assign fault        = fault_reg;
   assign fetch_fault  = ffault_reg;
   assign size_out     = size_reg;
   assign rom_limit    = rom_end_reg;
   assign ram_base     = ram_base_reg;
   assign fcall_ok     = fcall_ok_reg;
   assign fcall_target = fcall_tgt_reg;

   ////////////////////////////////////////////////////////////////////
   // Checks
   a_size_after_reset: assert property (
      @(posedge clk) $fell(rst) |-> size_out == `MSD_SIZE_RESET)
      else $error("size register not CFH after reset");

   a_size_hold: assert property (
      @(posedge clk) disable iff (rst)
      !size_wr |=> $stable(size_out))
      else $error("size register changed without a write");

   a_size_small: assert property (
      @(posedge clk) disable iff (rst)
      size_wr && size_wdata == `MSD_SIZE_8K |=>
         rom_limit == `MSD_ROM_END_8K && ram_base == `MSD_RAM_BASE_512)
      else $error("42H did not give 8 KB and 512 B");

   a_size_large: assert property (
      @(posedge clk) disable iff (rst)
      size_wr && size_wdata == `MSD_SIZE_32K |=>
         rom_limit == `MSD_ROM_END_32K && ram_base == `MSD_RAM_BASE_1K)
      else $error("C8H did not give 32 KB and 1 KB");

   a_rom_window: assert property (
      @(posedge clk) disable iff (rst)
      req && acc == mem_decode_pkg::ACC_READ && addr <= rom_limit |=>
         ack && region == mem_decode_pkg::RG_ROM && loc_addr == $past(addr))
      else $error("ROM address not decoded to ROM");

   sequence s_vec_start;
      vec_req && !vec_busy && slot_ok(vec_slot);
   endsequence
   a_vec_table: assert property (
      @(posedge clk) disable iff (rst)
      s_vec_start |=> rom_rd_en && rom_rd_addr <= `MSD_VEC_END
         ##1 rom_rd_addr == $past(rom_rd_addr) + 16'h0001)
      else $error("vector read outside the table");

   a_vec_slot: assert property (
      @(posedge clk) disable iff (rst)
      vec_req && !vec_busy && !slot_ok(vec_slot) |=> fault && !rom_rd_en)
      else $error("unused vector slot not refused");

   a_tcall_table: assert property (
      @(posedge clk) disable iff (rst)
      tcall_req && !vec_req && !vec_busy |=>
         rom_rd_addr >= `MSD_TCALL_BASE && rom_rd_addr <= `MSD_TCALL_END)
      else $error("table call entry outside its table");

   a_fcall_range: assert property (
      @(posedge clk) disable iff (rst)
      fcall_req |=> fcall_ok && fcall_target >= `MSD_FCALL_BASE
         && fcall_target <= `MSD_FCALL_END)
      else $error("fixed call target out of range");

   a_ram_window: assert property (
      @(posedge clk) disable iff (rst)
      req && acc == mem_decode_pkg::ACC_WRITE && addr >= ram_base
         && addr < `MSD_BANK_BASE |=>
         region == mem_decode_pkg::RG_RAM && !fault)
      else $error("RAM address not decoded to RAM");

   a_bank_nofetch: assert property (
      @(posedge clk) disable iff (rst)
      req && acc == mem_decode_pkg::ACC_FETCH && pc >= `MSD_BANK_BASE
         && pc <= `MSD_RAM_END |=> fetch_fault && fault)
      else $error("fetch from register banks not refused");

   a_stack_ram: assert property (
      @(posedge clk) disable iff (rst)
      req && acc == mem_decode_pkg::ACC_PUSH && addr < ram_base |=>
         fault && region == mem_decode_pkg::RG_NONE)
      else $error("stack access outside RAM not refused");

   a_sfr_window: assert property (
      @(posedge clk) disable iff (rst)
      req && acc == mem_decode_pkg::ACC_READ && addr >= `MSD_SFR_BASE |=>
         region == mem_decode_pkg::RG_SFR && loc_addr[7:0] == $past(addr[7:0]))
      else $error("peripheral window misdecoded");

   a_ext_gate: assert property (
      @(posedge clk) disable iff (rst)
      req && acc == mem_decode_pkg::ACC_READ && addr > rom_limit
         && addr < ram_base |=>
         (region == mem_decode_pkg::RG_EXT) == $past(ext_en)
         && fault == !$past(ext_en))
      else $error("gap access not gated by expansion");

   a_pc_fetch: assert property (
      @(posedge clk) disable iff (rst)
      req && acc == mem_decode_pkg::ACC_FETCH && pc <= rom_limit |=>
         region == mem_decode_pkg::RG_ROM && loc_addr == $past(pc))
      else $error("fetch not addressed by program counter");
endmodule

// *** dv/cpu_memory_space_decode_tb_top.sv ***
module cpu_memory_space_decode_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {
      mem_decode_pkg::region_t region;
      logic [15:0]             loc;
      logic                    flt;
      logic                    fflt;
      logic [4:0]              bank;
   } exp_t;
   logic                    clk, rst, req, size_wr, ext_en, vec_req;
   logic                    tcall_req, fcall_req, ack, fault, fetch_fault;
   logic                    vec_busy, vec_done, rom_rd_en, fcall_ok, en_q;
   mem_decode_pkg::access_t acc;
   mem_decode_pkg::region_t region;
   logic [15:0]             addr, pc, loc_addr, rom_limit, ram_base, vec_out;
   logic [15:0]             rom_rd_addr, fcall_target, addr_q, rom_end, ram_lo;
   logic [7:0]              size_wdata, rom_rd_data, size_out, key;
   logic [4:0]              vec_slot, tcall_idx, r;
   logic [10:0]             fcall_off;
   logic [1:0]              bank_sel;
   logic [2:0]              bank_reg;
   exp_t                    me;
   exp_t                    q_acc[$];
   logic [15:0]             q_vec[$], q_call[$];
   int                      n_mismatch, comparisons;

   mem_space_decode dut (.clk(clk), .rst(rst), .req(req), .acc(acc),
      .addr(addr), .pc(pc), .size_wr(size_wr), .size_wdata(size_wdata),
      .ext_en(ext_en), .vec_req(vec_req), .vec_slot(vec_slot),
      .tcall_req(tcall_req), .tcall_idx(tcall_idx), .fcall_req(fcall_req),
      .fcall_off(fcall_off), .rom_rd_data(rom_rd_data), .ack(ack),
      .region(region), .loc_addr(loc_addr), .bank_sel(bank_sel),
      .bank_reg(bank_reg), .fault(fault), .fetch_fault(fetch_fault),
      .size_out(size_out), .rom_limit(rom_limit), .ram_base(ram_base),
      .vec_busy(vec_busy), .vec_done(vec_done), .vec_out(vec_out),
      .rom_rd_en(rom_rd_en), .rom_rd_addr(rom_rd_addr),
      .fcall_ok(fcall_ok), .fcall_target(fcall_target));

   ////////////////////////////////////////////////////////////////////////
   // Clock and hang guard, sized well past the roughly 150 cycles used
   initial begin
      clk = 1'h0;
      forever #20 clk = ~clk;
   end
   initial begin
      repeat (20000) @(posedge clk);
      n_mismatch++;
      finish_test();
   end

   ////////////////////////////////////////////////////////////////////////
   function automatic logic [7:0] rom_byte(logic [15:0] a);
      return a[7:0] ^ a[15:8] ^ key;
   endfunction
   task automatic chk(string name, logic [15:0] exp, logic [15:0] got);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic finish_test();
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // ROM stand-in: byte valid only the cycle after a read, noise otherwise
   always @(posedge clk) begin
      en_q <= rom_rd_en;
      addr_q <= rom_rd_addr;
   end
   always @(negedge clk) begin
      rom_rd_data <= en_q ? rom_byte(addr_q) : 8'($urandom);
   end

   // Result watcher: oldest note against each answer as it appears
   always @(negedge clk) begin
      if (!rst && ack === 1'h1) begin
         me = q_acc.pop_front();
         chk("region", 16'(me.region), 16'(region));
         chk("fault", 16'(me.flt), 16'(fault));
         chk("fetch_fault", 16'(me.fflt), 16'(fetch_fault));
         if (me.region != mem_decode_pkg::RG_NONE) begin
            chk("loc_addr", me.loc, loc_addr);
         end
         if (me.region == mem_decode_pkg::RG_BANK) begin
            chk("bank", 16'(me.bank), 16'({bank_sel, bank_reg}));
         end
      end
      if (!rst && vec_done === 1'h1) begin
         chk("vec_out", q_vec.pop_front(), vec_out);
      end
      if (!rst && fcall_ok === 1'h1) begin
         chk("fcall_target", q_call.pop_front(), fcall_target);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // One access, left asserted so the next call runs back to back
   task automatic access(mem_decode_pkg::access_t k, logic [15:0] a,
                         logic x);
      exp_t e;
      logic f;
      f = (k == mem_decode_pkg::ACC_FETCH);
      e = '0;
      e.loc = a;
      if (f && a >= 16'hFEE0 && a <= 16'hFEFF) begin
         {e.flt, e.fflt} = 2'h3;
      end else if (k > mem_decode_pkg::ACC_WRITE && a < ram_lo) begin
         e.flt = 1'h1;
      end else if (a <= rom_end) begin
         e.region = mem_decode_pkg::RG_ROM;
      end else if (a < ram_lo) begin
         e.region = x ? mem_decode_pkg::RG_EXT : mem_decode_pkg::RG_NONE;
         e.flt = !x;
      end else if (a < 16'hFF00) begin
         e.region = a < 16'hFEE0 ? mem_decode_pkg::RG_RAM
                                 : mem_decode_pkg::RG_BANK;
         e.loc = a - ram_lo;
         e.bank = {~a[4:3], a[2:0]};
      end else begin
         e.region = mem_decode_pkg::RG_SFR;
         e.loc = {8'h00, a[7:0]};
      end
      q_acc.push_back(e);
      req = 1'h1;
      acc = k;
      ext_en = x;
      addr = f ? ~a : a;
      pc = f ? a : 16'($urandom);
      @(negedge clk);
   endtask

   // Vector or table word; a second request inside busy must be ignored.
   // Table call rides along with every vector, which must win.
   task automatic word(logic is_vec, logic [4:0] n);
      logic [15:0] b;
      b = (is_vec ? 16'h0000 : 16'h0040) + {10'h000, n, 1'h0};
      q_vec.push_back({rom_byte(b + 16'h0001), rom_byte(b)});
      vec_req = is_vec;
      tcall_req = 1'h1;
      vec_slot = n;
      tcall_idx = n;
      @(negedge clk);
      vec_req = 1'h0;
      chk("vec_busy", 16'h0001, 16'(vec_busy));
      @(negedge clk);
      tcall_req = 1'h0;
      repeat (4) @(negedge clk);
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      logic [7:0]  codes[4];
      logic [15:0] ends[4];
      logic [4:0]  slots[8];
      int          n_left;
      codes = '{8'h42, 8'h44, 8'hC6, 8'hC8};
      ends = '{16'h1FFF, 16'h3FFF, 16'h5FFF, 16'h7FFF};
      slots = '{5'h00, 5'h02, 5'h03, 5'h06, 5'h07, 5'h13, 5'h14, 5'h1F};
      {rst, req, size_wr, ext_en, vec_req, tcall_req, fcall_req} = 7'h40;
      acc = mem_decode_pkg::ACC_READ;
      {addr, pc, size_wdata, vec_slot, tcall_idx, fcall_off} = '0;
      void'($urandom(39));
      key = 8'($urandom);
      repeat (16) @(negedge clk);
      rst = 1'h0;
      @(negedge clk);
      chk("size_out", 16'h00CF, 16'(size_out));
      chk("rom_limit", 16'h7FFF, rom_limit);
      chk("ram_base", 16'hFB00, ram_base);
      foreach (codes[i]) begin
         size_wr = 1'h1;
         size_wdata = codes[i];
         @(negedge clk);
         size_wr = 1'h0;
         rom_end = ends[i];
         ram_lo = i < 2 ? 16'hFD00 : 16'hFB00;
         chk("size_out", 16'(codes[i]), 16'(size_out));
         chk("rom_limit", rom_end, rom_limit);
         chk("ram_base", ram_lo, ram_base);
         r = 5'($urandom);
         access(mem_decode_pkg::ACC_READ, rom_end, 1'h0);
         access(mem_decode_pkg::ACC_READ, rom_end + 1, 1'h0);
         access(mem_decode_pkg::ACC_WRITE, rom_end + 1, 1'h1);
         access(mem_decode_pkg::ACC_READ, ram_lo - 1, 1'h1);
         access(mem_decode_pkg::ACC_WRITE, ram_lo, 1'h0);
         access(mem_decode_pkg::ACC_PUSH, ram_lo - 1, 1'h1);
         access(mem_decode_pkg::ACC_POP, 16'hFEFF, 1'h0);
         access(mem_decode_pkg::ACC_READ, 16'hFEE0 + r, 1'h0);
         access(mem_decode_pkg::ACC_FETCH, 16'hFEE0 + r, 1'h0);
         access(mem_decode_pkg::ACC_WRITE, 16'hFF00 + r, 1'h0);
         access(mem_decode_pkg::ACC_READ, 16'($urandom), 1'h1);
         access(mem_decode_pkg::ACC_FETCH, 16'($urandom) & rom_end,
                1'h0);
         req = 1'h0;
         repeat (2) @(negedge clk);
      end
      foreach (slots[i]) word(1'h1, slots[i]);
      word(1'h0, 5'h00);
      word(1'h0, 5'h1F);
      vec_req = 1'h1;
      vec_slot = 5'h01;
      @(negedge clk);
      vec_req = 1'h0;
      chk("fault_slot", 16'h0001, 16'({fault, rom_rd_en}) ^ 16'h0003);
      repeat (3) @(negedge clk);
      repeat (6) begin
         fcall_off = 11'($urandom);
         q_call.push_back({5'h01, fcall_off});
         fcall_req = 1'h1;
         @(negedge clk);
      end
      fcall_req = 1'h0;
      repeat (4) @(negedge clk);
      n_left = q_acc.size() + q_vec.size() + q_call.size();
      chk("pending", 16'h0000, 16'(n_left));
      finish_test();
   end
endmodule
